// ==== rtl/sfaso_top.sv ====
// Fault acknowledge sequencer and three two-channel safe outputs
`timescale 1ns/1ns
module sfaso_top
  import sfaso_pkg::*;
#(
  parameter int ACK_CLR_CYCLES   = ACK_CLR_MIN_CYC,
  parameter int TP_PERIOD_CYCLES = TP_PERIOD_CYC
)(
  input  wire logic                               CLK,
  input  wire logic                               RESET,
  input  wire logic                               DEFAULT_ACK_INPUT,
  input  wire logic [NUM_CTRL-1:0]                CTRL_PORTS,
  input  wire logic [3:0]                         ACK_SOURCE_SELECTOR,
  input  wire logic [NUM_ERR-1:0]                 ERROR_RAISE,
  input  wire logic [NUM_ERR-1:0]                 ERROR_CONDITION,
  input  wire logic [NUM_ERR-1:0]                 VIOLATION_MASK,
  input  wire logic [NUM_ERR-1:0]                 FUNCTION_REQUESTED,
  input  wire logic [NUM_VOUT-1:0]                VIRTUAL_OUTPUT_SOURCES,
  input  wire logic [NUM_OUT-1:0][NUM_VOUT-1:0]   OUT_SOURCE_MASK,
  input  wire logic [NUM_OUT-1:0]                 OUT_LEVEL_INVERT,
  input  wire logic [NUM_OUT-1:0][1:0]            OUTPUT_MODE_SETTING,
  input  wire logic [NUM_OUT-1:0][PW_W-1:0]       PULSE_WIDTH_SETTING,
  input  wire logic [NUM_OUT-1:0]                 READBACK_A,
  input  wire logic [NUM_OUT-1:0]                 READBACK_B,
  input  wire logic                               INTERNAL_FAULT,
  output logic [NUM_OUT-1:0]                      SAFE_OUTPUT_CHAN_A,
  output logic [NUM_OUT-1:0]                      SAFE_OUTPUT_CHAN_B,
  output logic [NUM_OUT-1:0]                      OUTPUT_FAULT,
  output logic [NUM_ERR-1:0]                      ERROR_BUFFER,
  output logic                                    FAULT_STATE,
  output logic                                    ACK_BUSY,
  output logic                                    LOG_VALID,
  output logic                                    LOG_IS_ACK,
  output logic [4:0]                              LOG_ERR_INDEX,
  output logic                                    BU_ACK_CMD
);

  // ==========================================================
  // State
  typedef struct packed {
    logic                ack_s1;
    logic                ack_s2;
    logic                ack_prev;
    sfaso_state_t        st;
    logic [WAIT_W-1:0]   wait_cnt;
    logic [4:0]          idx;
    logic [NUM_ERR-1:0]  err_buf;
    logic                fault_state;
    logic                busy;
    logic                log_valid;
    logic                log_is_ack;
    logic [4:0]          log_idx;
    logic                bu_cmd;
    logic                fault_clr;
    logic [NUM_OUT-1:0]  level;
  } sfaso_top_t;

  sfaso_top_t          s_r;
  sfaso_top_t          s_nxt;
  logic                sel_ack;
  logic                ack_pulse;
  logic [NUM_ERR-1:0]  raise_v;
  logic [NUM_ERR-1:0]  persist_v;
  logic [NUM_OUT-1:0]  out_fault;

  // edge of the second synchroniser stage only
  assign ack_pulse = s_r.ack_s2 & ~s_r.ack_prev;

  // ==========================================================
  // Acknowledge source and error vectors
  always_comb
  begin
    sel_ack = 1'b0;
    // selector zero is the default input
    if (ACK_SOURCE_SELECTOR == ACK_SEL_DEFAULT)
      sel_ack = DEFAULT_ACK_INPUT;
    // other ports are simply not looked at
    else if (ACK_SOURCE_SELECTOR <= ACK_SEL_LAST)
      sel_ack = CTRL_PORTS[3'(ACK_SOURCE_SELECTOR - 4'h1)];
    // Codes above the last port route nothing and never acknowledge
    raise_v = ERROR_RAISE;
    raise_v[OUT_FAULT_ERR_IDX] = ERROR_RAISE[OUT_FAULT_ERR_IDX] | (|out_fault);
    // violation persists only while out of range and requested
    // request alone never keeps an error
    persist_v = ERROR_CONDITION & (~VIOLATION_MASK | FUNCTION_REQUESTED);
    persist_v[OUT_FAULT_ERR_IDX] = persist_v[OUT_FAULT_ERR_IDX] | (|out_fault);
  end

  // ==========================================================
  // Acknowledge sequencer
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.ack_s1 = sel_ack;
    s_nxt.ack_s2 = s_r.ack_s1;
    s_nxt.ack_prev = s_r.ack_s2;
    s_nxt.log_valid = 1'b0;
    s_nxt.log_is_ack = 1'b0;
    s_nxt.bu_cmd = 1'b0;
    s_nxt.fault_clr = 1'b0;
    // buffer only ever grows outside the clear step
    s_nxt.err_buf = s_r.err_buf | raise_v;
    // Edges that arrive mid-sequence are dropped, never queued
    unique case (s_r.st)
      SFASO_IDLE:
      begin
        // a held level gives no new pulse
        if (ack_pulse)
        begin
          s_nxt.st = SFASO_WAIT;
          s_nxt.wait_cnt = '0;
          // Outputs get a fresh read-back trial during the wait
          s_nxt.fault_clr = 1'b1;
        end
      end
      SFASO_WAIT:
      begin
        // clear lands at the minimum time after the edge
        if (s_r.wait_cnt == WAIT_W'(ACK_CLR_CYCLES - 1))
          s_nxt.st = SFASO_CLEAR;
        else
          s_nxt.wait_cnt = s_r.wait_cnt + 1'b1;
      end
      SFASO_CLEAR:
      begin
        // keep live errors, new raises win
        s_nxt.err_buf = (s_r.err_buf & persist_v) | raise_v;
        s_nxt.st = SFASO_LOGA;
      end
      SFASO_LOGA:
      begin
        s_nxt.log_valid = 1'b1;
        s_nxt.log_is_ack = 1'b1;
        s_nxt.idx = '0;
        s_nxt.st = SFASO_RELOG;
      end
      SFASO_RELOG:
      begin
        // log each remaining error again
        // One index a cycle keeps the walk short and bounded
        if (s_r.err_buf[s_r.idx])
        begin
          s_nxt.log_valid = 1'b1;
          s_nxt.log_idx = s_r.idx;
        end
        if (s_r.idx == LAST_ERR_IDX)
          s_nxt.st = SFASO_CMD;
        else
          s_nxt.idx = s_r.idx + 5'h01;
      end
      SFASO_CMD:
      begin
        // basic unit clears its own errors after this
        s_nxt.bu_cmd = 1'b1;
        s_nxt.st = SFASO_IDLE;
      end
      default:
        s_nxt.st = SFASO_IDLE;
    endcase
    s_nxt.fault_state = |s_nxt.err_buf;
    s_nxt.busy = s_nxt.st != SFASO_IDLE;
    // Registered level gives every output one clean copy
    // masked OR with optional inversion
    for (int i = 0; i < NUM_OUT; i++)
      s_nxt.level[i] = (|(VIRTUAL_OUTPUT_SOURCES & OUT_SOURCE_MASK[i])) ^ OUT_LEVEL_INVERT[i];
  end

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      s_r.ack_s1      <= 1'b0;
      s_r.ack_s2      <= 1'b0;
      s_r.ack_prev    <= 1'b0;
      s_r.st          <= SFASO_IDLE;
      s_r.wait_cnt    <= '0;
      s_r.idx         <= '0;
      s_r.err_buf     <= '0;
      s_r.fault_state <= 1'b0;
      s_r.busy        <= 1'b0;
      s_r.log_valid   <= 1'b0;
      s_r.log_is_ack  <= 1'b0;
      s_r.log_idx     <= '0;
      s_r.bu_cmd      <= 1'b0;
      s_r.fault_clr   <= 1'b0;
      s_r.level       <= '0;
    end
    else
      s_r <= s_nxt;
  end

  // ==========================================================
  // Safe outputs
  // Test pulses staggered so no two outputs pulse together
  for (genvar g = 0; g < NUM_OUT; g++)
  begin : g_out
    // Every 2-bit code is a legal mode, so the cast is safe
    // two register stages, far inside the delay limit
    sfaso_safe_out #(
      .TP_PERIOD (TP_PERIOD_CYCLES),
      .TP_OFFSET ((TP_PERIOD_CYCLES / NUM_OUT) * g)
    ) u_out (
      .clk       (CLK),
      .reset     (RESET),
      .mode      (sfaso_mode_t'(OUTPUT_MODE_SETTING[g])),
      .level     (s_r.level[g]),
      .force_off (INTERNAL_FAULT),
      .pulse_len (PULSE_WIDTH_SETTING[g]),
      .rb_a      (READBACK_A[g]),
      .rb_b      (READBACK_B[g]),
      .fault_clr (s_r.fault_clr),
      .chan_a    (SAFE_OUTPUT_CHAN_A[g]),
      .chan_b    (SAFE_OUTPUT_CHAN_B[g]),
      .fault     (out_fault[g])
    );
  end

  assign OUTPUT_FAULT  = out_fault;
  assign ERROR_BUFFER  = s_r.err_buf;
  assign FAULT_STATE   = s_r.fault_state;
  assign ACK_BUSY      = s_r.busy;
  assign LOG_VALID     = s_r.log_valid;
  assign LOG_IS_ACK    = s_r.log_is_ack;
  assign LOG_ERR_INDEX = s_r.log_idx;
  assign BU_ACK_CMD    = s_r.bu_cmd;

  // ==========================================================
  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  sequence held_high_s;
    s_r.ack_s2 && s_r.ack_prev;
  endsequence

  sequence cmd_pulse_s;
    BU_ACK_CMD ##1 !BU_ACK_CMD;
  endsequence

  ack_edge_start_a: assert property (s_r.st == SFASO_IDLE && ack_pulse |=> s_r.st == SFASO_WAIT)
    else $error("Edge did not start acknowledge");
  held_level_a: assert property (((s_r.st == SFASO_IDLE) and held_high_s) |=> s_r.st == SFASO_IDLE)
    else $error("Held level started acknowledge");
  clear_timing_a: assert property ($rose(s_r.st == SFASO_CLEAR) |-> $past(s_r.wait_cnt) == WAIT_W'(ACK_CLR_CYCLES - 1))
    else $error("Clear reached at wrong time");
  buffer_hold_a: assert property (s_r.st != SFASO_CLEAR |=> (s_r.err_buf & $past(s_r.err_buf)) == $past(s_r.err_buf))
    else $error("Buffer dropped an error outside clear");
  ack_record_a: assert property (s_r.st == SFASO_LOGA |=> LOG_VALID && LOG_IS_ACK ##1 !LOG_IS_ACK)
    else $error("Acknowledge record missing");
  relog_entry_a: assert property (s_r.st == SFASO_RELOG && s_r.err_buf[s_r.idx]
                                  |=> LOG_VALID && LOG_ERR_INDEX == $past(s_r.idx))
    else $error("Remaining error not logged again");
  cmd_once_a: assert property (s_r.st == SFASO_CMD |=> cmd_pulse_s)
    else $error("Acknowledge command not one pulse");
  pulse_single_a: assert property (ack_pulse |=> !ack_pulse)
    else $error("Acknowledge pulse longer than one cycle");

  // ==========================================================
  // Sequence walk, sources and forced state
  // Record step right after the clear
  sequence record_step_s;
    s_r.st == SFASO_RELOG && s_r.idx == 5'h00 && LOG_IS_ACK;
  endsequence

  // Command pulse closes the sequence
  sequence command_step_s;
    s_r.st == SFASO_CMD ##1 s_r.st == SFASO_IDLE && BU_ACK_CMD && !ACK_BUSY;
  endsequence

  clear_to_record_a: assert property (s_r.st == SFASO_CLEAR |=> s_r.st == SFASO_LOGA ##1 record_step_s)
    else $error("Acknowledge record step skipped");
  relog_span_a: assert property (s_r.st == SFASO_LOGA |-> ##33 command_step_s)
    else $error("Re-entry walk has wrong length");
  relog_silent_a: assert property (s_r.st == SFASO_RELOG && !s_r.err_buf[s_r.idx] |=> !LOG_VALID)
    else $error("Record for an empty buffer bit");
  log_idx_hold_a: assert property (s_r.st != SFASO_RELOG |=> $stable(LOG_ERR_INDEX))
    else $error("Record index moved outside the walk");
  live_kept_a: assert property (s_r.st == SFASO_CLEAR
                                |=> ERROR_BUFFER == $past((s_r.err_buf & persist_v) | raise_v))
    else $error("Clear dropped a live error");
  wait_hold_a: assert property (s_r.st == SFASO_WAIT && s_r.wait_cnt != WAIT_W'(ACK_CLR_CYCLES - 1)
                                |=> s_r.st == SFASO_WAIT)
    else $error("Wait left before its count");

  idle_quiet_a: assert property (s_r.st == SFASO_IDLE && !ack_pulse |=> !ACK_BUSY && !LOG_VALID)
    else $error("Sequence ran without an edge");
  busy_start_a: assert property ($rose(ACK_BUSY) |-> $past(ack_pulse))
    else $error("Busy rose without an edge");
  trial_clear_a: assert property ($rose(ACK_BUSY) |-> s_r.fault_clr)
    else $error("Output faults not retried at acknowledge");
  default_source_a: assert property (ACK_SOURCE_SELECTOR == ACK_SEL_DEFAULT
                                     |=> s_r.ack_s1 == $past(DEFAULT_ACK_INPUT))
    else $error("Default input not routed");
  unrouted_source_a: assert property (ACK_SOURCE_SELECTOR > ACK_SEL_LAST |=> !s_r.ack_s1)
    else $error("Unrouted selector fed the acknowledge");

  // Top-level view of the forced safe state
  fault_to_buffer_a: assert property ((|out_fault) |=> ERROR_BUFFER[OUT_FAULT_ERR_IDX])
    else $error("Output fault not in error buffer");
  forced_pins_a: assert property (INTERNAL_FAULT |=> (SAFE_OUTPUT_CHAN_A | SAFE_OUTPUT_CHAN_B) == '0)
    else $error("Internal fault left a channel high");
endmodule // sfaso_top

// ==== rtl/sfaso_pkg.sv ====
// Constants and types for the fault acknowledge and safe output block
// Functional notes
// - Acknowledge starts only on a rising edge; a held high level does nothing.
// - Selector value zero routes the default single-channel input to the acknowledge.
// - Acknowledge removes errors whose condition has ended, and violation errors not requested; others stay buffered.
// - Each acknowledge writes one acknowledge record to the event log.
// - After acknowledge, every remaining error is logged again.
// - At the end, one acknowledge command pulse goes to the basic unit.
// - Module errors clear only through this acknowledge, never by the basic unit.
// - Only the selected control port may start an acknowledge.
// - Buffer clear and mode change happen 4 ms to 20 ms after the edge.
// - Basic unit clears its errors and is ready 20 ms to 500 ms later.
// - Violation errors persist only while out of range and still requested.
// - A pending request alone never blocks acknowledge of an error.
// - Each logical output level is the OR of masked virtual sources.
// - Each output runs in off, on, equivalent or antivalent mode.
// - Equivalent mode drives both channels to the logical level.
// - Antivalent mode drives A to the level and B to its inverse.
// - Test pulse width comes from a per-output setting.
// - Both channels are read back continuously and checked against drive.
// - A read-back mismatch switches that output off and raises the output fault.
// - An internal fault forces every channel low, antivalent ones too.
// - An output set permanently on carries the test pulses.
// - A level change reaches the channels within 2.5 ms.
package sfaso_pkg;
  localparam int CLK_PERIOD_NS   = 50;
  localparam int ACK_CLR_MIN_US  = 4000;
  localparam int ACK_CLR_MAX_US  = 20000;
  localparam int ACK_CLR_MIN_CYC = (ACK_CLR_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACK_CLR_MAX_CYC = (ACK_CLR_MAX_US * 1000) / CLK_PERIOD_NS;
  localparam int TS_MAX_US       = 2500;
  localparam int TS_MAX_CYC      = (TS_MAX_US * 1000) / CLK_PERIOD_NS;
  localparam int TP_MIN_US       = 400;
  localparam int TP_MAX_US       = 10000;
  localparam int TP_MIN_CYC      = (TP_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TP_MAX_CYC      = (TP_MAX_US * 1000) / CLK_PERIOD_NS;
  localparam int TP_PERIOD_US    = 100000;
  localparam int TP_PERIOD_CYC   = (TP_PERIOD_US * 1000) / CLK_PERIOD_NS;
  localparam int RB_SETTLE_CYC   = 4;
  localparam int NUM_OUT         = 3;
  localparam int NUM_ERR         = 32;
  localparam int NUM_CTRL        = 8;
  localparam int NUM_VOUT        = 16;
  localparam int WAIT_W          = 19;
  localparam int TP_CNT_W        = 22;
  localparam int PW_W            = 18;
  localparam logic [4:0] OUT_FAULT_ERR_IDX = 5'h18;
  localparam logic [4:0] LAST_ERR_IDX      = 5'h1F;
  localparam logic [3:0] ACK_SEL_DEFAULT   = 4'h0;
  localparam logic [3:0] ACK_SEL_LAST      = 4'h8;

  typedef enum logic [1:0] {
    SFASO_OFF   = 2'h0,
    SFASO_EQUIV = 2'h1,
    SFASO_ANTI  = 2'h2,
    SFASO_ON    = 2'h3
  } sfaso_mode_t;

  typedef enum logic [2:0] {
    SFASO_IDLE  = 3'h0,
    SFASO_WAIT  = 3'h1,
    SFASO_CLEAR = 3'h3,
    SFASO_LOGA  = 3'h2,
    SFASO_RELOG = 3'h6,
    SFASO_CMD   = 3'h7
  } sfaso_state_t;
endpackage

// ==== rtl/sfaso_safe_out.sv ====
// One two-channel safe output with test pulses and read-back check
`timescale 1ns/1ns
module sfaso_safe_out
  import sfaso_pkg::*;
#(
  parameter int TP_PERIOD = TP_PERIOD_CYC,
  parameter int TP_OFFSET = 0
)(
  input  wire logic            clk,
  input  wire logic            reset,
  input  wire sfaso_mode_t     mode,
  input  wire logic            level,
  input  wire logic            force_off,
  input  wire logic [PW_W-1:0] pulse_len,
  input  wire logic            rb_a,
  input  wire logic            rb_b,
  input  wire logic            fault_clr,
  output logic                 chan_a,
  output logic                 chan_b,
  output logic                 fault
);
  typedef struct packed {
    logic [TP_CNT_W-1:0] tp_cnt;
    logic [2:0]          settle;
    logic                a;
    logic                b;
    logic                fault;
  } sfaso_so_t;

  sfaso_so_t s_r;
  sfaso_so_t s_nxt;
  logic [PW_W-1:0] plen;
  logic            pulse;
  logic            want_a;
  logic            want_b;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.tp_cnt = (s_r.tp_cnt == TP_CNT_W'(TP_PERIOD - 1)) ? '0 : s_r.tp_cnt + 1'b1;
    // width clamped to the legal pulse range
    plen = pulse_len;
    if (plen < PW_W'(TP_MIN_CYC))
      plen = PW_W'(TP_MIN_CYC);
    else if (plen > PW_W'(TP_MAX_CYC))
      plen = PW_W'(TP_MAX_CYC);
    pulse = s_r.tp_cnt < TP_CNT_W'(plen);
    unique case (mode)
      SFASO_OFF:   begin want_a = 1'b0;  want_b = 1'b0;   end
      SFASO_EQUIV: begin want_a = level; want_b = level;  end
      SFASO_ANTI:  begin want_a = level; want_b = ~level; end
      SFASO_ON:    begin want_a = 1'b1;  want_b = 1'b1;   end
    endcase
    // high channels carry the test pulses
    s_nxt.a = want_a & ~pulse;
    s_nxt.b = want_b & ~pulse;
    // faulted or forced output is low on both pins
    if (s_r.fault || force_off)
    begin
      s_nxt.a = 1'b0;
      s_nxt.b = 1'b0;
    end
    // Pin edges need time before read-back is trusted
    if (s_nxt.a != s_r.a || s_nxt.b != s_r.b)
      s_nxt.settle = 3'(RB_SETTLE_CYC);
    else if (s_r.settle != 3'h0)
      s_nxt.settle = s_r.settle - 3'h1;
    if (fault_clr)
      s_nxt.fault = 1'b0;
    // read-back check, detection wins over clear
    if (s_r.settle == 3'h0 && (rb_a != s_r.a || rb_b != s_r.b))
      s_nxt.fault = 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s_r.tp_cnt <= TP_CNT_W'(TP_OFFSET);
      s_r.settle <= 3'(RB_SETTLE_CYC);
      s_r.a      <= 1'b0;
      s_r.b      <= 1'b0;
      s_r.fault  <= 1'b0;
    end
    else
      s_r <= s_nxt;
  end

  assign chan_a = s_r.a;
  assign chan_b = s_r.b;
  assign fault  = s_r.fault;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  fault_pins_low_a: assert property (s_r.fault |=> !s_r.a && !s_r.b)
    else $error("Faulted output not low");
  force_off_low_a: assert property (force_off |=> !s_r.a && !s_r.b)
    else $error("Forced output not low");
  anti_b_low_a: assert property ((mode == SFASO_ANTI) && level |=> !s_r.b)
    else $error("Antivalent channel B high at level one");
endmodule // sfaso_safe_out

// ==== dv/sfaso_bu_model.sv ====
// Basic unit partner: event log counters, ack command and read-back wiring
`timescale 1ns/1ns
module sfaso_bu_model
  import sfaso_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                reset,
  input  wire logic [NUM_OUT-1:0]  chan_a,
  input  wire logic [NUM_OUT-1:0]  chan_b,
  input  wire logic [NUM_OUT-1:0]  short_lo_a,
  input  wire logic                log_valid,
  input  wire logic                log_is_ack,
  input  wire logic                bu_ack_cmd,
  output logic      [NUM_OUT-1:0]  rb_a,
  output logic      [NUM_OUT-1:0]  rb_b,
  output logic      [15:0]         ack_rec_cnt,
  output logic      [15:0]         relog_cnt,
  output logic      [15:0]         cmd_cnt,
  output logic                     bu_pending
);
  // ==========================================================
  // Read-back path
  // Short to ground pulls channel A low whatever is driven
  assign rb_a = chan_a & ~short_lo_a;
  assign rb_b = chan_b;

  // ==========================================================
  // Event memory and own error handling
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      ack_rec_cnt <= 16'h0000;
      relog_cnt   <= 16'h0000;
      cmd_cnt     <= 16'h0000;
      bu_pending  <= 1'b0;
    end
    else
    begin
      if (log_valid && log_is_ack)
        ack_rec_cnt <= ack_rec_cnt + 16'h0001;
      if (log_valid && !log_is_ack)
        relog_cnt <= relog_cnt + 16'h0001;
      // own errors cleared on command only, module buffer untouched
      if (bu_ack_cmd)
      begin
        cmd_cnt    <= cmd_cnt + 16'h0001;
        bu_pending <= 1'b0;
      end
      else if (log_valid && !log_is_ack)
        bu_pending <= 1'b1;
    end
  end
endmodule // sfaso_bu_model

// ==== dv/sfaso_top_tb.sv ====
// Self-checking bench for acknowledge sequencer and safe outputs
`timescale 1ns/1ns
module sfaso_top_tb
  import sfaso_pkg::*;
;
  localparam int ACK_N = 20;
  localparam int TPP   = 30000;
  logic clk = 1'b0, rst = 1'b1, dflt = 1'b0, intf = 1'b0;
  logic [NUM_CTRL-1:0] ctrl = '0;
  logic [3:0] sel = ACK_SEL_DEFAULT;
  logic [NUM_ERR-1:0] raise = '0, cond = '0, viol = '0, req = '0;
  logic [NUM_VOUT-1:0] vsrc = '0;
  logic [NUM_OUT-1:0][NUM_VOUT-1:0] smask = {16'h0004, 16'h0002, 16'h0001};
  logic [NUM_OUT-1:0] inv = '0, shrt = '0;
  logic [NUM_OUT-1:0][1:0] mode = '0;
  logic [NUM_OUT-1:0][PW_W-1:0] pw = {3{18'h0_2328}};
  logic [NUM_OUT-1:0] ca, cb, ofl, rba, rbb;
  logic [NUM_ERR-1:0] ebuf;
  logic fst, busy, lv, lack, cmd, pend;
  logic [4:0] lidx;
  logic [15:0] n_ack, n_rel, n_cmd;
  int err_total = 0, checked = 0;

  always #25 clk = ~clk;

  sfaso_top #(.ACK_CLR_CYCLES(ACK_N), .TP_PERIOD_CYCLES(TPP)) i_dut (
    .CLK(clk), .RESET(rst), .DEFAULT_ACK_INPUT(dflt), .CTRL_PORTS(ctrl), .ACK_SOURCE_SELECTOR(sel),
    .ERROR_RAISE(raise), .ERROR_CONDITION(cond), .VIOLATION_MASK(viol), .FUNCTION_REQUESTED(req),
    .VIRTUAL_OUTPUT_SOURCES(vsrc), .OUT_SOURCE_MASK(smask), .OUT_LEVEL_INVERT(inv),
    .OUTPUT_MODE_SETTING(mode), .PULSE_WIDTH_SETTING(pw), .READBACK_A(rba), .READBACK_B(rbb),
    .INTERNAL_FAULT(intf), .SAFE_OUTPUT_CHAN_A(ca), .SAFE_OUTPUT_CHAN_B(cb), .OUTPUT_FAULT(ofl),
    .ERROR_BUFFER(ebuf), .FAULT_STATE(fst), .ACK_BUSY(busy), .LOG_VALID(lv), .LOG_IS_ACK(lack),
    .LOG_ERR_INDEX(lidx), .BU_ACK_CMD(cmd));

  sfaso_bu_model i_bu (
    .clk(clk), .reset(rst), .chan_a(ca), .chan_b(cb), .short_lo_a(shrt), .log_valid(lv),
    .log_is_ack(lack), .bu_ack_cmd(cmd), .rb_a(rba), .rb_b(rbb), .ack_rec_cnt(n_ack),
    .relog_cnt(n_rel), .cmd_cnt(n_cmd), .bu_pending(pend));

  // ==========================================================
  // Shared helpers
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n)
    begin
      @(posedge clk);
      #5;
    end
  endtask

  task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Bounded waits; an expired bound closes the run
  task automatic wait_busy(input logic lvl, input int lim);
    int i;
    i = 0;
    while (busy !== lvl && i < lim)
    begin
      step(1);
      i++;
    end
    if (busy !== lvl)
    begin
      cmp("busy wait", 32'(lvl), 32'(busy));
      end_sim();
    end
  endtask

  task automatic wait_chan(input int g, input logic ea, input logic eb);
    int i;
    i = 0;
    while ((ca[g] !== ea || cb[g] !== eb) && i < 12000)
    begin
      step(1);
      i++;
    end
    if (ca[g] !== ea || cb[g] !== eb)
    begin
      cmp("channel wait", 32'({ea, eb}), 32'({ca[g], cb[g]}));
      end_sim();
    end
  endtask

  // Source -1 is the default input, k selects control port k
  task automatic rise(input int k);
    if (k < 0) dflt = 1'b0; else ctrl[k] = 1'b0;
    step(3);
    if (k < 0) dflt = 1'b1; else ctrl[k] = 1'b1;
  endtask

  task automatic raise_err(input logic [31:0] b);
    raise = b;
    step(1);
    raise = '0;
    step(2);
  endtask

  task automatic idle_busy(input int n, output int hits);
    hits = 0;
    repeat (n)
    begin
      step(1);
      if (busy !== 1'b0) hits++;
    end
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_ack();
    logic [15:0] a0, r0, c0;
    int cnt, hits;
    cond = 32'h0000_00A0;
    viol = 32'h0000_0080;
    req  = 32'h0000_0100;
    raise_err(32'h0000_01A8);
    cmp("buffer set", 32'h0000_01A8, ebuf);
    a0 = n_ack;
    r0 = n_rel;
    c0 = n_cmd;
    rise(-1);
    cnt = 0;
    while (ebuf === 32'h0000_01A8 && cnt < 200)
    begin
      step(1);
      cnt++;
    end
    cmp("clear delay in range", 32'h1, 32'(cnt >= ACK_N && cnt <= ACK_N + 10));
    wait_busy(1'b0, 200);
    cmp("command pulse", 32'h1, 32'(cmd));
    step(1);
    cmp("unit pending", 32'h0, 32'(pend));
    cmp("buffer after ack", 32'h0000_0020, ebuf);
    cmp("fault state", 32'h1, 32'(fst));
    cmp("ack records", 32'h1, 32'(n_ack - a0));
    cmp("re-entries", 32'h1, 32'(n_rel - r0));
    cmp("re-entry index", 32'h5, 32'(lidx));
    cmp("unit commands", 32'h1, 32'(n_cmd - c0));
    idle_busy(100, hits);
    cmp("held level busy", 32'h0, 32'(hits));
    cond = '0;
    raise_err(32'h0000_0000);
    rise(-1);
    wait_busy(1'b1, 10);
    wait_busy(1'b0, 200);
    cmp("buffer empty", 32'h0, ebuf);
  endtask

  task automatic t_select();
    int hits;
    sel = 4'h3;
    raise_err(32'h0000_0008);
    rise(-1);
    idle_busy(40, hits);
    cmp("unselected port busy", 32'h0, 32'(hits));
    cmp("buffer kept", 32'h0000_0008, ebuf);
    sel = 4'h9;
    rise(3);
    idle_busy(40, hits);
    cmp("unrouted selector busy", 32'h0, 32'(hits));
    sel = 4'h3;
    rise(2);
    wait_busy(1'b1, 10);
    wait_busy(1'b0, 200);
    cmp("selected port clear", 32'h0, ebuf);
    sel = ACK_SEL_DEFAULT;
    ctrl = '0;
    dflt = 1'b0;
  endtask

  task automatic t_modes();
    logic ea, eb, l;
    for (int m = 0; m < 4; m++)
      for (int k = 0; k < 2; k++)
      begin
        l = k[0];
        mode[0] = m[1:0];
        vsrc[0] = l;
        ea = (m == 3) || ((m == 1 || m == 2) && l);
        eb = (m == 3) || (m == 1 && l) || (m == 2 && !l);
        wait_chan(0, ea, eb);
        cmp("chan a by mode", 32'(ea), 32'(ca[0]));
        cmp("chan b by mode", 32'(eb), 32'(cb[0]));
      end
  endtask

  task automatic t_pulse();
    int lows;
    mode[0] = SFASO_ON;
    step(10);
    lows = 0;
    repeat (TPP)
    begin
      step(1);
      if (ca[0] !== 1'b1) lows++;
    end
    cmp("pulse low cycles", 32'h0000_2328, 32'(lows));
    cmp("healthy fault", 32'h0, 32'(ofl));
  endtask

  task automatic t_short();
    int i;
    mode[1] = SFASO_EQUIV;
    vsrc[1] = 1'b1;
    wait_chan(1, 1'b1, 1'b1);
    shrt[1] = 1'b1;
    i = 0;
    while (ofl[1] !== 1'b1 && i < 12000)
    begin
      step(1);
      i++;
    end
    step(3);
    cmp("output fault", 32'h1, 32'(ofl[1]));
    cmp("faulted channels", 32'h0, 32'({ca[1], cb[1]}));
    cmp("fault error bit", 32'h1, 32'(ebuf[OUT_FAULT_ERR_IDX]));
    shrt[1] = 1'b0;
    rise(-1);
    wait_busy(1'b1, 10);
    wait_busy(1'b0, 200);
    step(10);
    cmp("fault after ack", 32'h0, 32'(ofl[1]));
    cmp("buffer after fault ack", 32'h0, ebuf);
    dflt = 1'b0;
  endtask

  task automatic t_internal();
    mode[2] = SFASO_ANTI;
    // inverted so a low level is the safe one
    inv[2] = 1'b1;
    vsrc[2] = 1'b1;
    wait_chan(2, 1'b0, 1'b1);
    intf = 1'b1;
    step(2);
    cmp("forced chan a", 32'h0, 32'(ca));
    cmp("forced chan b", 32'h0, 32'(cb));
    intf = 1'b0;
    inv[2] = 1'b0;
  endtask

  task automatic t_delay();
    int cnt;
    mode[2] = SFASO_EQUIV;
    vsrc[2] = 1'b0;
    wait_chan(2, 1'b0, 1'b0);
    vsrc[2] = 1'b1;
    cnt = 0;
    while (ca[2] !== 1'b1 && cnt <= TS_MAX_CYC)
    begin
      step(1);
      cnt++;
    end
    cmp("level delay bound", 32'h1, 32'(cnt <= TS_MAX_CYC));
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    step(20);
    rst = 1'b0;
    step(3);
    t_ack();
    t_select();
    t_modes();
    t_pulse();
    t_short();
    t_internal();
    t_delay();
    end_sim();
  end
endmodule // sfaso_top_tb
